// ===== hdl/adc_autoscan_sequencer.sv
/*
  Autoscan sequencer for an eight-channel successive-approximation converter:
  prescaled timing, channel walk, start interlock and result buffering.
  Assumes all inputs are synchronous to I_CORE_CLK and that software strobes
  are one clock wide; the analog core answers with a settled result by the
  storage cycle.
*/
`timescale 1ns/100ps
module adc_autoscan_sequencer #(
  parameter int unsigned MC_DIV = adc_seq_pkg::MC_DIV_DEF  // clocks per machine cycle
) (
  input  wire logic                            I_CORE_CLK,       // system clock
  input  wire logic                            I_RESET,          // async reset, high
  input  wire logic [adc_seq_pkg::PRE_W-1:0]   I_PRESCALE_SEL,   // prescale_select_high/low
  input  wire logic                            I_CONT_SCAN,      // continuous_scan_select
  input  wire logic                            I_RISE_EN,        // rising_start_enable
  input  wire logic                            I_FALL_EN,        // falling_start_enable
  input  wire logic [adc_seq_pkg::NUM_CH-1:0]  I_CHAN_SEL,       // channel_scan_select
  input  wire logic                            I_EXT_START_PIN,  // external start pin
  input  wire logic                            I_START_WR,       // software writes start flag
  input  wire logic                            I_START_VAL,      // value written to start flag
  input  wire logic                            I_DONE_CLR,       // software clears done flag
  input  wire logic                            I_RES_RD,         // read of a low result byte
  input  wire logic [adc_seq_pkg::CH_W-1:0]    I_RES_IDX,        // which low byte is read
  input  wire logic [adc_seq_pkg::RES_W-1:0]   I_ANA_RESULT,     // result from analog core
  output logic                                 O_START_STATUS,   // effective start flag
  output logic                                 O_SCAN_DONE,      // scan-done flag
  output logic [adc_seq_pkg::LOW_W-1:0]        O_RES_LOW,        // low result byte
  output logic [adc_seq_pkg::LOW_W-1:0]        O_RES_HIGH,       // high result register
  output adc_seq_pkg::ana_ctrl_t               O_ANA             // strobes to analog core
);

  // elaboration-time check of the machine-cycle divider
  if (MC_DIV < 1 || MC_DIV > 255) begin : g_bad_div
    $error("MC_DIV must lie in 1..255");
  end

  adc_seq_pkg::seq_state_t              state_r;
  logic [adc_seq_pkg::MC_CNT_W-1:0]     mc_cnt_r;
  logic                                 mc_tick;
  logic [1:0]                           pre_cnt_r;
  logic [1:0]                           half_m;
  logic [adc_seq_pkg::CNT_W-1:0]        m_cyc;
  logic                                 adc_tick;
  logic [adc_seq_pkg::CNT_W-1:0]        cnt_r;
  logic [1:0]                           sub_r;
  logic [adc_seq_pkg::CH_W-1:0]         ch_r;
  logic [adc_seq_pkg::NUM_CH-1:0]       sel_r;
  logic                                 start_r;
  logic                                 pend_r;
  logic                                 done_r;
  logic                                 pin_q_r;
  logic                                 pin_edge;
  logic                                 sw_set;
  logic                                 set_req;
  logic                                 phase_end;
  logic                                 store_end;
  logic                                 has_next;
  logic [adc_seq_pkg::CH_W-1:0]         next_ch;
  logic [adc_seq_pkg::CH_W-1:0]         first_ch;
  logic                                 loop_last;
  logic                                 restart;
  logic                                 rd_q_r;
  logic [adc_seq_pkg::RES_W-1:0]        rdata;
  logic [adc_seq_pkg::HIGH_W-1:0]       high_r;

  // machine-cycle tick from the system clock
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      mc_cnt_r <= 8'h00;
    end else if (mc_cnt_r == adc_seq_pkg::MC_CNT_W'(MC_DIV - 1)) begin
      mc_cnt_r <= 8'h00;
    end else begin
      mc_cnt_r <= mc_cnt_r + 8'h01;
    end
  end
  assign mc_tick = (mc_cnt_r == adc_seq_pkg::MC_CNT_W'(MC_DIV - 1));

  // bit period is m/2 machine cycles, so half_m equals the code, one less than m/2
  assign half_m = I_PRESCALE_SEL;
  assign m_cyc  = {3'h0, I_PRESCALE_SEL, 1'b0} + 6'h02;

  // free-running divided converter clock; the start phase against it
  // gives the m/2 spread in start latency
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pre_cnt_r <= 2'h0;
    end else if (mc_tick) begin
      pre_cnt_r <= (pre_cnt_r >= half_m) ? 2'h0 : pre_cnt_r + 2'h1;
    end
  end
  assign adc_tick = mc_tick && (pre_cnt_r >= half_m);

  // pin is synchronous; edge found against the previous sample
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      pin_q_r <= 1'b0;
    end else begin
      pin_q_r <= I_EXT_START_PIN;
    end
  end
  assign pin_edge = (I_RISE_EN && I_EXT_START_PIN && !pin_q_r) ||
                    (I_FALL_EN && !I_EXT_START_PIN && pin_q_r);
  assign sw_set   = I_START_WR && I_START_VAL;
  assign set_req  = sw_set || pin_edge || pend_r;

  // first and next selected channel searches
  always_comb begin
    first_ch = '0;
    for (int i = adc_seq_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (I_CHAN_SEL[i]) begin
        first_ch = adc_seq_pkg::CH_W'(i);
      end
    end
  end

  always_comb begin
    has_next = 1'b0;
    next_ch  = ch_r;
    for (int i = adc_seq_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (sel_r[i] && (adc_seq_pkg::CH_W'(i) > ch_r)) begin
        has_next = 1'b1;
        next_ch  = adc_seq_pkg::CH_W'(i);
      end
    end
  end

  assign loop_last = !has_next;
  assign store_end = (state_r == adc_seq_pkg::ST_STORE) && mc_tick;
  // a restart takes the live selection, so a write during a loop waits for the next one
  assign restart   = store_end && loop_last && I_CONT_SCAN && (I_CHAN_SEL != '0);

  // start/status flag and the request held while done is set
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      start_r <= 1'b0;
      pend_r  <= 1'b0;
    end else if (I_START_WR && !I_START_VAL) begin
      start_r <= 1'b0;
      pend_r  <= 1'b0;
    end else if (!start_r) begin
      if (set_req && done_r) begin
        pend_r  <= 1'b1;
      end else if (set_req && (I_CHAN_SEL != '0)) begin
        start_r <= 1'b1;
        pend_r  <= 1'b0;
      end
    end else if (store_end && loop_last && !restart) begin
      start_r <= 1'b0;
    end
  end

  // scan-done flag: a store in the clearing cycle wins over the clear
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      done_r <= 1'b0;
    end else if (store_end && loop_last && start_r) begin
      done_r <= 1'b1;
    end else if (I_DONE_CLR) begin
      done_r <= 1'b0;
    end
  end

  // phase length in machine cycles for the current state
  always_comb begin
    phase_end = 1'b0;
    unique case (state_r)
      adc_seq_pkg::ST_SAMPLE:  phase_end = (cnt_r == m_cyc - 6'h01);
      adc_seq_pkg::ST_CONVERT: phase_end = (cnt_r == 6'((m_cyc * 5) - 1));
      adc_seq_pkg::ST_STORE:   phase_end = 1'b1;
      adc_seq_pkg::ST_INIT:    phase_end = (cnt_r == m_cyc - 6'h02);
      default:                 phase_end = 1'b0;
    endcase
  end

  // an abort drops straight to idle with no store, so a cut conversion never
  // overwrites the buffer word of its channel
  // sequence walk; every conversion runs inside a loop
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      state_r <= adc_seq_pkg::ST_IDLE;
      cnt_r   <= 6'h00;
      ch_r    <= 3'h0;
      sel_r   <= 8'h00;
    end else if (!start_r) begin
      state_r <= adc_seq_pkg::ST_IDLE;
      cnt_r   <= 6'h00;
    end else if (state_r == adc_seq_pkg::ST_IDLE) begin
      if (adc_tick) begin
        state_r <= adc_seq_pkg::ST_SAMPLE;
        cnt_r   <= 6'h00;
        sel_r   <= I_CHAN_SEL;
        ch_r    <= first_ch;
      end
    end else if (mc_tick) begin
      if (!phase_end) begin
        cnt_r <= cnt_r + 6'h01;
      end else begin
        cnt_r <= 6'h00;
        unique case (state_r)
          adc_seq_pkg::ST_SAMPLE:  state_r <= adc_seq_pkg::ST_CONVERT;
          adc_seq_pkg::ST_CONVERT: state_r <= adc_seq_pkg::ST_STORE;
          adc_seq_pkg::ST_STORE: begin
            if (has_next) begin
              state_r <= adc_seq_pkg::ST_INIT;
              ch_r    <= next_ch;
            end else if (restart) begin
              state_r <= adc_seq_pkg::ST_INIT;
              sel_r   <= I_CHAN_SEL;
              ch_r    <= first_ch;
            end else begin
              state_r <= adc_seq_pkg::ST_IDLE;
            end
          end
          adc_seq_pkg::ST_INIT:    state_r <= adc_seq_pkg::ST_SAMPLE;
          default:                 state_r <= adc_seq_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // bit-step divider: one decision per m/2 machine cycles
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sub_r <= 2'h0;
    end else if (state_r != adc_seq_pkg::ST_CONVERT) begin
      sub_r <= 2'h0;
    end else if (mc_tick) begin
      sub_r <= (sub_r >= half_m) ? 2'h0 : sub_r + 2'h1;
    end
  end

  // strobes to the core; sample is held for the whole sample period
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_ANA <= '0;
    end else begin
      O_ANA.chan     <= ch_r;
      O_ANA.sample   <= (state_r == adc_seq_pkg::ST_SAMPLE) && start_r;
      O_ANA.bit_step <= (state_r == adc_seq_pkg::ST_CONVERT) && start_r &&
                        mc_tick && (sub_r >= half_m);
    end
  end

  // result buffer, written at the end of the storage cycle
  adc_result_mem #(
    .DEPTH (adc_seq_pkg::NUM_CH),
    .AW    (adc_seq_pkg::CH_W),
    .DW    (adc_seq_pkg::RES_W)
  ) u_mem (
    .i_clk   (I_CORE_CLK),
    .i_we    (store_end && start_r),
    .i_waddr (ch_r),
    .i_wdata (I_ANA_RESULT),
    .i_re    (I_RES_RD),
    .i_raddr (I_RES_IDX),
    .o_rdata (rdata)
  );

  // low byte and upper-bit latch taken together, so a later high read
  // always matches the low byte just read
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      rd_q_r    <= 1'b0;
      O_RES_LOW <= 8'h00;
      high_r    <= 2'h0;
    end else begin
      rd_q_r <= I_RES_RD;
      if (rd_q_r) begin
        O_RES_LOW <= rdata[adc_seq_pkg::LOW_W-1:0];
        high_r    <= rdata[adc_seq_pkg::RES_W-1:adc_seq_pkg::LOW_W];
      end
    end
  end

  assign O_RES_HIGH     = {6'h00, high_r};
  assign O_START_STATUS = start_r;
  assign O_SCAN_DONE    = done_r;

endmodule

// ===== hdl/adc_result_mem.sv
/*
  Result buffer: one word per channel, written at the storage cycle.
  Read data leave through a register one clock after the read request.
  Contents are not reset, as the result registers are undefined after reset.
*/
`timescale 1ns/100ps
module adc_result_mem #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned AW    = 3,
  parameter int unsigned DW    = 10
) (
  input  wire logic          i_clk,    // system clock
  input  wire logic          i_we,     // write strobe
  input  wire logic [AW-1:0] i_waddr,  // write channel
  input  wire logic [DW-1:0] i_wdata,  // result to keep
  input  wire logic          i_re,     // read strobe
  input  wire logic [AW-1:0] i_raddr,  // read channel
  output logic      [DW-1:0] o_rdata   // registered read data
);

  // the write and read addresses must be wide enough to reach every word
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("DEPTH must lie in 1..2**AW");
  end

  logic [DW-1:0] mem_r [DEPTH];

  // plain array write, no reset so it maps onto a small RAM
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // registered read port
  always_ff @(posedge i_clk) begin
    if (i_re) begin
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule

// ===== hdl/adc_seq_pkg.sv
/*
  Shared constants and types for the converter autoscan sequencer.
  Assumes a single system clock; all sequencing runs on machine-cycle ticks.
*/
package adc_seq_pkg;

  localparam int unsigned NUM_CH      = 8;   // analog inputs
  localparam int unsigned CH_W        = 3;   // channel index width
  localparam int unsigned RES_W       = 10;  // conversion result width
  localparam int unsigned LOW_W       = 8;   // low result byte width
  localparam int unsigned HIGH_W      = 2;   // upper result bits held in latch
  localparam int unsigned PRE_W       = 2;   // prescaler select width
  localparam int unsigned MC_DIV_DEF  = 12;  // system clocks per machine cycle
  localparam int unsigned SAMPLE_BITS = 2;   // sample period in bit periods
  localparam int unsigned CONV_BITS   = 10;  // bit periods of approximation
  localparam int unsigned STORE_MC    = 1;   // machine cycles to store result
  localparam int unsigned CNT_W       = 6;   // phase counter, holds 5*8
  localparam int unsigned BIT_CNT_W   = 4;   // counts the ten bit steps
  localparam int unsigned MC_CNT_W    = 8;   // machine-cycle divider width

  // prescale divisor m = 2 * (code + 1): 00->2, 01->4, 10->6, 11->8
  localparam logic [PRE_W-1:0] PRE_RESET = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,  // no scan running
    ST_SAMPLE  = 3'b001,  // input tracked by the sample switch
    ST_CONVERT = 3'b010,  // successive approximation steps
    ST_STORE   = 3'b011,  // one machine cycle writing the result
    ST_INIT    = 3'b100   // selects the next channel before sampling
  } seq_state_t;

  // strobes toward the analog core
  typedef struct packed {
    logic [CH_W-1:0] chan;      // channel on the input multiplexer
    logic            sample;    // level: sample switch closed
    logic            bit_step;  // pulse: take the next bit decision
  } ana_ctrl_t;

endpackage

// ===== test/adc_autoscan_sequencer_properties.sv
/*
  Timing and flag checks for the autoscan sequencer, bound to its ports.
  Assumes prescale and mode stay steady while a loop runs.
*/
`timescale 1ns/100ps
module adc_seq_checker #(parameter int unsigned MC_DIV = 12) (
  input wire logic                           I_CORE_CLK,      // clock
  input wire logic                           I_RESET,         // reset
  input wire logic [adc_seq_pkg::PRE_W-1:0]  I_PRESCALE_SEL,  // prescale
  input wire logic                           I_CONT_SCAN,     // mode
  input wire logic [adc_seq_pkg::NUM_CH-1:0] I_CHAN_SEL,      // channels
  input wire logic                           I_START_WR,      // start write
  input wire logic                           I_START_VAL,     // start value
  input wire logic                           I_DONE_CLR,      // done clear
  input wire logic                           I_RES_RD,        // result read
  input wire logic                           O_START_STATUS,  // start flag
  input wire logic                           O_SCAN_DONE,     // done flag
  input wire logic [adc_seq_pkg::LOW_W-1:0]  O_RES_LOW,       // low byte
  input wire logic [adc_seq_pkg::LOW_W-1:0]  O_RES_HIGH,      // high bits
  input wire adc_seq_pkg::ana_ctrl_t         O_ANA            // strobes
);
  int unsigned m_clk;      // clocks in m machine cycles
  logic [11:0] per_r;      // clocks since sampling began
  logic [3:0]  nb_r;       // bit steps since sampling began
  logic [7:0]  gap_r;      // clocks since last bit step
  logic [2:0]  last_ch_r;  // channel of previous sample
  logic        run_r;      // start flag held since that sample
  assign m_clk = 2 * (int'(I_PRESCALE_SEL) + 1) * MC_DIV;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  // counts restart at each sampling so an abort never leaks into the next loop
  always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      per_r <= 12'h000;
      nb_r <= 4'h0;
      gap_r <= 8'h00;
      last_ch_r <= 3'h0;
      run_r <= 1'b0;
    end else begin
      gap_r <= O_ANA.bit_step ? 8'h01 : gap_r + 8'h01;
      if ($rose(O_ANA.sample)) begin
        per_r <= 12'h001;
        nb_r <= 4'h0;
        last_ch_r <= O_ANA.chan;
        run_r <= O_START_STATUS;
      end else begin
        per_r <= per_r + 12'h001;
        nb_r <= nb_r + 4'(O_ANA.bit_step);
        if (!O_START_STATUS) run_r <= 1'b0;
      end
    end
  end
  a_high_bits_zero: assert property (O_RES_HIGH[7:2] == 6'h00)
    else $error("high result register upper bits set");
  a_read_hold: assert property (!$past(I_RES_RD, 2) |-> $stable(O_RES_LOW) && $stable(O_RES_HIGH))
    else $error("result bytes changed without a read");
  a_sample_len: assert property ($fell(O_ANA.sample) && O_START_STATUS |-> per_r == m_clk)
    else $error("sample period length wrong");
  a_conv_spacing: assert property ($rose(O_ANA.sample) && run_r && O_ANA.chan > last_ch_r
                                   |-> per_r == 7 * m_clk)
    else $error("conversions not 7m machine cycles apart");
  a_ten_steps: assert property ($rose(O_ANA.sample) && run_r && O_ANA.chan > last_ch_r
                                |-> nb_r == 4'hA)
    else $error("bit step count per conversion wrong");
  a_step_gap: assert property (O_ANA.bit_step && nb_r != 4'h0 |-> gap_r == m_clk / 2)
    else $error("bit step spacing wrong");
  a_sw_start: assert property (I_START_WR && I_START_VAL && !O_START_STATUS && !O_SCAN_DONE
                               && I_CHAN_SEL != 8'h00 |=> O_START_STATUS)
    else $error("software start not taken");
  a_sw_abort: assert property (I_START_WR && !I_START_VAL |=> !O_START_STATUS)
    else $error("start flag kept after software clear");
  a_start_blocked: assert property (O_SCAN_DONE && !O_START_STATUS |=> !O_START_STATUS)
    else $error("start flag set while done flag set");
  a_done_sticky: assert property (O_SCAN_DONE && !I_DONE_CLR |=> O_SCAN_DONE)
    else $error("done flag cleared without software");
  a_done_clear: assert property (I_DONE_CLR && !O_START_STATUS |=> !O_SCAN_DONE)
    else $error("done flag not cleared");
  a_loop_end: assert property ($rose(O_SCAN_DONE) |->
                               $past(O_START_STATUS) && O_START_STATUS == I_CONT_SCAN)
    else $error("start flag wrong at loop end");
endmodule
bind adc_autoscan_sequencer adc_seq_checker #(.MC_DIV(MC_DIV)) chk_u (.I_CORE_CLK, .I_RESET, .I_PRESCALE_SEL,
  .I_CONT_SCAN, .I_CHAN_SEL, .I_START_WR, .I_START_VAL, .I_DONE_CLR, .I_RES_RD, .O_START_STATUS, .O_SCAN_DONE,
  .O_RES_LOW, .O_RES_HIGH, .O_ANA);

// ===== test/adc_core_model.sv
/*
  Analog core stand-in: answers each conversion with {channel, salt}.
  Assumes the sequencer strobes of O_ANA and a salt held by the bench.
*/
`timescale 1ns/100ps
module adc_core_model (
  input  wire logic                   i_clk,    // system clock
  input  wire logic                   i_reset,  // async reset, high
  input  wire adc_seq_pkg::ana_ctrl_t i_ana,    // sequencer strobes
  input  wire logic [6:0]             i_salt,   // low bits of results
  output logic [9:0]                  o_result  // result to sequencer
);
  logic [3:0] n_step_r;  // decisions taken in this conversion
  // the bus churns until ten decisions are in, so an early store shows up
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      n_step_r <= 4'h0;
      o_result <= 10'h000;
    end else if (i_ana.sample) begin
      n_step_r <= 4'h0;
      o_result <= ~o_result;
    end else if (n_step_r == 4'hA) begin
      o_result <= {i_ana.chan, i_salt};
    end else begin
      n_step_r <= n_step_r + 4'(i_ana.bit_step);
      // the tenth decision settles the word at once, so it stands through the store cycle
      o_result <= (i_ana.bit_step && n_step_r == 4'h9) ? {i_ana.chan, i_salt} : ~o_result;
    end
  end
endmodule

// ===== test/test_adc_autoscan_sequencer.sv
/*
  Self-checking bench for the autoscan sequencer with an analog core model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/100ps
module test_adc_autoscan_sequencer;
  localparam int unsigned MCD = 2;  // short machine cycle keeps the run brief
  logic clk, rst, cont, rise_en, fall_en, pin, st_wr, st_val, dn_clr, rd, st, dn, samp_q;
  logic [1:0] pre_sel;
  logic [2:0] rd_idx;
  logic [6:0] salt;
  logic [7:0] chan_sel, r_lo, r_hi, ev, sa, sb;
  logic [9:0] ana_res;
  logic [9:0] exp_r [8];
  logic [2:0] chq [$];  // channels in sampling order
  adc_seq_pkg::ana_ctrl_t ana;
  int miscompares, n_checks, seed_v;
  adc_autoscan_sequencer #(.MC_DIV(MCD)) dut_u (.I_CORE_CLK(clk), .I_RESET(rst), .I_PRESCALE_SEL(pre_sel),
    .I_CONT_SCAN(cont), .I_RISE_EN(rise_en), .I_FALL_EN(fall_en), .I_CHAN_SEL(chan_sel), .I_EXT_START_PIN(pin),
    .I_START_WR(st_wr), .I_START_VAL(st_val), .I_DONE_CLR(dn_clr), .I_RES_RD(rd), .I_RES_IDX(rd_idx),
    .I_ANA_RESULT(ana_res), .O_START_STATUS(st), .O_SCAN_DONE(dn), .O_RES_LOW(r_lo), .O_RES_HIGH(r_hi), .O_ANA(ana));
  adc_core_model core_u (.i_clk(clk), .i_reset(rst), .i_ana(ana), .i_salt(salt), .o_result(ana_res));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // record each new sampling so channel order can be compared
  // taken on the falling edge, where the registered strobes have settled
  always @(negedge clk) begin
    if (ana.sample && !samp_q) chq.push_back(ana.chan);
    samp_q <= ana.sample;
  end
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // a stored word is the channel above the salt, as the core model forms it
  function automatic logic [9:0] exp_res(input int ch, input logic [6:0] s);
    return {3'(ch), s};
  endfunction
  task automatic clks(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic sw(input logic v);
    st_wr = 1'b1;
    st_val = v;
    clks(1);
    st_wr = 1'b0;
  endtask
  task automatic clr_done;
    dn_clr = 1'b1;
    clks(1);
    dn_clr = 1'b0;
    clks(1);
  endtask
  // bounded wait; a hang shows as a failed done compare
  task automatic wait_done;
    for (int i = 0; i < 4000 && dn !== 1'b1; i++) clks(1);
    chk(dn, 1'b1);
  endtask
  task automatic chk_order(input logic [7:0] sel);
    for (int i = 0; i < 8; i++)
      if (sel[i]) chk(chq.size() ? 10'(chq.pop_front()) : 10'h3FF, 10'(i));
    chk(10'(chq.size()), 10'h000);
  endtask
  // k: 0 software, 1 rising pin, 2 falling pin, 3 both edges enabled
  task automatic start_by(input int k);
    pin = (k != 2);
    clks(2);
    pin = (k == 2);
    clks(3);
    chk(st, 1'b0);
    rise_en = k[0];
    fall_en = k[1];
    clks(1);
    if (k == 0) sw(1'b1);
    else pin = ~pin;
    clks(3);
    chk(st, 1'b1);
    rise_en = 1'b0;
    fall_en = 1'b0;
  endtask
  task automatic one_loop(input int k);
    sa = 8'($urandom) | (8'h01 << ($urandom % 8));
    salt = 7'($urandom);
    pre_sel = 2'(k);
    chan_sel = sa;
    start_by(k);
    wait_done;
    chk(st, 1'b0);
    chk_order(sa);
    for (int i = 0; i < 8; i++)
      if (sa[i]) exp_r[i] = exp_res(i, salt);
    ev = ev | sa;
    // words never written are unknown, so only written channels are read
    for (int i = 0; i < 8; i++) begin
      if (ev[i]) begin
        rd = 1'b1;
        rd_idx = 3'(i);
        clks(1);
        rd = 1'b0;
        clks(2);
        chk(10'(r_lo), 10'(exp_r[i][7:0]));
        chk(10'(r_hi), 10'(exp_r[i][9:8]));
      end
    end
    clr_done;
    chk(dn, 1'b0);
  endtask
  initial begin
    {rst, cont, rise_en, fall_en, pin, st_wr, st_val, dn_clr, rd} = 9'h100;
    {pre_sel, rd_idx, salt, chan_sel, ev} = 28'h0000000;
    miscompares = 0;
    n_checks = 0;
    seed_v = $urandom(32'h0457);
    repeat (6) @(posedge clk);
    clks(1);
    rst = 1'b0;
    clks(2);
    chk(st, 1'b0);
    chk(dn, 1'b0);
    sw(1'b1);
    clks(2);
    chk(st, 1'b0);
    for (int k = 0; k < 4; k++) one_loop(k);
    // start while done is set is held until software clears done
    chan_sel = 8'h10;
    sw(1'b1);
    wait_done;
    chk_order(8'h10);
    sw(1'b1);
    {rise_en, fall_en} = 2'h3;
    pin = ~pin;
    clks(3);
    {rise_en, fall_en} = 2'h0;
    chk(st, 1'b0);
    clr_done;
    clks(2);
    chk(st, 1'b1);
    wait_done;
    chk_order(8'h20 >> 1);
    clr_done;
    // continuous scan with a mid-loop selection change, then abort
    cont = 1'b1;
    sa = 8'($urandom) | 8'h80;
    sb = 8'($urandom) | 8'h01;
    chan_sel = sa;
    sw(1'b1);
    clks(8);
    chan_sel = sb;
    wait_done;
    chk(st, 1'b1);
    chk_order(sa);
    clr_done;
    wait_done;
    chk_order(sb);
    clr_done;
    sw(1'b0);
    clks(1);
    chk(st, 1'b0);
    clks(80);
    chk(dn, 1'b0);
    chk(10'(ana.sample), 10'h000);
    end_sim;
  end
  // watchdog well beyond the longest expected run
  initial begin
    #1000000;
    miscompares++;
    end_sim;
  end
endmodule
